// File: bench/adc_analog_model.sv
// Analog multiplexer and comparator in front of the converter.
`timescale 1ns/1ps
module adc_analog_model
(
    input  wire logic                           pclk,
    input  wire adc_ctrl_pkg::analog_ctrl_type  analog,
    input  wire logic [adc_ctrl_pkg::RESULT_W-1:0] level [8],
    output logic                                compare_high
);
    logic flip = 1'b0;

    // Outside a conversion the comparator output carries no meaning.
    always @(posedge pclk)
        flip <= ~flip;
    assign compare_high = analog.mux_enable ?
        (level[analog.mux_select] >= analog.trial_code) : flip;
endmodule

// File: bench/adc_ctrl_properties.sv
// Concurrent checks on the converter control block ports.
`timescale 1ns/1ps
module adc_ctrl_properties
(
    input wire logic                            pclk,
    input wire logic                            presetn,
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                     pwdata,
    input wire logic [31:0]                     prdata,
    input wire logic                            pready,
    input wire logic                            pslverr,
    input wire logic                            compare_high,
    input wire adc_ctrl_pkg::analog_ctrl_type   analog,
    input wire logic [7:0]                      pin_analog_mode,
    input wire logic                            irq_request,
    input wire logic                            cpu_halt,
    input wire logic                            irq_hold
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A conversion opens with a sample period of at least two clocks.
    sequence conv_begin;
        $rose(analog.mux_enable);
    endsequence
    sequence sample_min;
        analog.sample_hold [*2];
    endsequence

    a_sample_span: assert property (conv_begin |-> sample_min)
        else $error("sample period shorter than two clocks");
    a_pin_gate: assert property (conv_begin |->
        pin_analog_mode[analog.mux_select] && analog.power_on)
        else $error("conversion on unconfigured or powered-down input");
    a_first_trial: assert property ($fell(analog.sample_hold) &&
        analog.mux_enable |-> analog.trial_code == adc_ctrl_pkg::MSB_MASK)
        else $error("first trial code is not the top bit");
    a_chan_hold: assert property (analog.mux_enable &&
        $past(analog.mux_enable) |-> $stable(analog.mux_select))
        else $error("channel changed during conversion");
    a_ready_now: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_err_access: assert property (pslverr |-> psel && penable && pready)
        else $error("error outside access phase");
    a_hold_halt: assert property (irq_hold == cpu_halt)
        else $error("interrupt hold differs from halt");
    a_halt_conv: assert property (cpu_halt |-> analog.mux_enable)
        else $error("halt outside conversion");
    a_irq_clear: assert property (psel && penable && pwrite &&
        paddr == adc_ctrl_pkg::ADDR_CONTROL && !analog.mux_enable &&
        !pwdata[adc_ctrl_pkg::CTL_DONE] |=> !irq_request)
        else $error("interrupt stays after done cleared");
endmodule

bind adc_conversion_control adc_ctrl_properties u_adc_ctrl_properties
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .compare_high(compare_high),
    .analog(analog), .pin_analog_mode(pin_analog_mode),
    .irq_request(irq_request), .cpu_halt(cpu_halt), .irq_hold(irq_hold)
);

// File: bench/tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module tb;
    logic                            pclk = 1'b0;
    logic                            presetn = 1'b0;
    logic                            psel = 1'b0;
    logic                            penable = 1'b0;
    logic                            pwrite = 1'b0;
    logic [adc_ctrl_pkg::ADDR_W-1:0] paddr = 12'h000;
    logic [31:0]                     pwdata = 32'h0;
    logic [31:0]                     prdata;
    logic                            pready;
    logic                            pslverr;
    logic                            compare_high;
    adc_ctrl_pkg::analog_ctrl_type   analog;
    logic [7:0]                      pin_analog_mode;
    logic                            irq_request;
    logic                            cpu_halt;
    logic                            irq_hold;
    logic [9:0]                      level [8];
    logic [31:0]                     rd;
    logic [31:0]                     ctl;
    logic                            err;
    int                              n_mismatch = 0;
    int                              checks = 0;
    int                              busy_n = 0;
    int                              per;
    int                              base;
    int          cfg_div [3] = '{1, 3, 0};
    logic [2:0]  cfg_ch [3] = '{3'h7, 3'h0, 3'h5};
    logic [9:0]  cfg_code [3] = '{10'h3FF, 10'h000, 10'h2A5};
    logic        cfg_q [3] = '{1'b0, 1'b1, 1'b0};
    logic        cfg_ie [3] = '{1'b1, 1'b1, 1'b0};
    logic [11:0] regs [6] = '{adc_ctrl_pkg::ADDR_CLOCK_DIV,
        adc_ctrl_pkg::ADDR_CONTROL, adc_ctrl_pkg::ADDR_RESULT_LOW,
        adc_ctrl_pkg::ADDR_RESULT_HIGH, adc_ctrl_pkg::ADDR_PIN_CONFIG,
        adc_ctrl_pkg::ADDR_IRQ_ENABLE};

    always #20 pclk = ~pclk;
    always @(posedge pclk)
        if (analog.mux_enable)
            busy_n <= busy_n + 1;

    adc_conversion_control u_adc_conversion_control
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .compare_high(compare_high),
        .analog(analog), .pin_analog_mode(pin_analog_mode),
        .irq_request(irq_request), .cpu_halt(cpu_halt), .irq_hold(irq_hold)
    );
    adc_analog_model u_adc_analog_model
    (
        .pclk(pclk), .analog(analog), .level(level),
        .compare_high(compare_high)
    );

    task check(input string name, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp, input string n);
        apb(1'b0, a, 32'h0);
        check(n, rd, exp);
    endtask

    task tally_and_finish;
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        tally_and_finish;
    end

    initial
    begin
        for (int i = 0; i < 8; i++)
            level[i] = 10'h155;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd_chk(regs[i], 32'h0, "reset value");
        apb(1'b0, 12'h004, 32'h0);
        check("unmapped error", 32'(err), 32'h1);
        apb(1'b1, adc_ctrl_pkg::ADDR_CLOCK_DIV, 32'hFF);
        rd_chk(adc_ctrl_pkg::ADDR_CLOCK_DIV, 32'h1F, "divider");
        apb(1'b1, adc_ctrl_pkg::ADDR_PIN_CONFIG, 32'hFF);
        @(negedge pclk);
        check("pin mode", 32'(pin_analog_mode), 32'hFF);
        apb(1'b1, adc_ctrl_pkg::ADDR_CONTROL, 32'h8F);
        rd_chk(adc_ctrl_pkg::ADDR_CONTROL, 32'h07, "standby");
        check("power", 32'(analog.power_on), 32'h0);
        apb(1'b1, adc_ctrl_pkg::ADDR_CONTROL, 32'h20);
        repeat (10) @(posedge pclk);
        apb(1'b1, adc_ctrl_pkg::ADDR_PIN_CONFIG, 32'h7F);
        apb(1'b1, adc_ctrl_pkg::ADDR_CONTROL, 32'h2F);
        rd_chk(adc_ctrl_pkg::ADDR_CONTROL, 32'h27, "no start");
        check("mux idle", 32'(analog.mux_enable), 32'h0);
        apb(1'b1, adc_ctrl_pkg::ADDR_RESULT_HIGH, 32'hFF);
        rd_chk(adc_ctrl_pkg::ADDR_RESULT_HIGH, 32'h0, "read only");
        apb(1'b1, adc_ctrl_pkg::ADDR_PIN_CONFIG, 32'hFF);
        for (int i = 0; i < 3; i++)
        begin
            level[cfg_ch[i]] <= cfg_code[i];
            per = cfg_div[i] == 0 ? adc_ctrl_pkg::DIV_ZERO_RATIO :
                adc_ctrl_pkg::DIV_STEP * cfg_div[i];
            apb(1'b1, adc_ctrl_pkg::ADDR_CLOCK_DIV, 32'(cfg_div[i]));
            apb(1'b1, adc_ctrl_pkg::ADDR_IRQ_ENABLE,
                {30'h0, cfg_ie[i], 1'b0});
            ctl = {25'h0, cfg_q[i], 3'h5, cfg_ch[i]};
            base = busy_n;
            apb(1'b1, adc_ctrl_pkg::ADDR_CONTROL, ctl);
            rd_chk(adc_ctrl_pkg::ADDR_CONTROL, ctl, "busy");
            check("halt", 32'(cpu_halt), 32'(cfg_q[i]));
            check("irq hold", 32'(irq_hold), 32'(cfg_q[i]));
            check("mux select", 32'(analog.mux_select), 32'(cfg_ch[i]));
            for (int k = 0; k < 2000 && analog.mux_enable; k++)
                @(negedge pclk);
            check("length", 32'(busy_n - base),
                32'(adc_ctrl_pkg::CONV_PERIODS * per));
            rd_chk(adc_ctrl_pkg::ADDR_RESULT_HIGH, 32'(cfg_code[i] >> 2),
                "high");
            rd_chk(adc_ctrl_pkg::ADDR_RESULT_LOW, 32'(cfg_code[i][1:0]),
                "low");
            rd_chk(adc_ctrl_pkg::ADDR_CONTROL, ctl ^ 32'h18, "done");
            check("irq", 32'(irq_request), 32'(cfg_ie[i]));
            check("released", 32'(cpu_halt), 32'h0);
            apb(1'b1, adc_ctrl_pkg::ADDR_CONTROL, 32'h20);
            rd_chk(adc_ctrl_pkg::ADDR_CONTROL, 32'h20, "cleared");
            check("irq off", 32'(irq_request), 32'h0);
        end
        apb(1'b1, adc_ctrl_pkg::ADDR_CONTROL, 32'h2D);
        apb(1'b1, adc_ctrl_pkg::ADDR_CONTROL, 32'h2A);
        check("latched", 32'(analog.mux_select), 32'h5);
        apb(1'b1, adc_ctrl_pkg::ADDR_CONTROL, 32'h00);
        rd_chk(adc_ctrl_pkg::ADDR_CONTROL, 32'h00, "abort");
        check("abort idle", 32'(analog.mux_enable), 32'h0);
        rd_chk(adc_ctrl_pkg::ADDR_RESULT_HIGH, 32'hA9, "kept");
        tally_and_finish;
    end
endmodule

// File: src/adc_clock_divider.sv
// Converter clock prescaler producing one tick per converter period.
`timescale 1ns/1ps
module adc_clock_divider
#(
    parameter int FIELD_W = adc_ctrl_pkg::DIV_FIELD_W
)
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               restart,
    input  wire logic [FIELD_W-1:0] divider_field,
    output logic                    tick
);

    localparam int CNT_W = 7;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] terminal;
    logic [CNT_W-1:0] next_count;

    // Zero selects the fixed ratio, otherwise twice the field value.
    assign terminal = (divider_field == '0)
        ? CNT_W'(adc_ctrl_pkg::DIV_ZERO_RATIO - 1)
        : CNT_W'(adc_ctrl_pkg::DIV_STEP * int'(divider_field) - 1);

    assign tick       = (count >= terminal) && !restart;
    assign next_count = (restart || count >= terminal)
        ? '0
        : CNT_W'(count + 1'b1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= '0;
        end
        else
        begin
            count <= next_count;
        end
    end

endmodule

// File: src/adc_conversion_control.sv
// Converter control: APB registers, conversion sequencer and CPU hold.
//
// Behaviour
// - A written start bit launches exactly one conversion.
// - Hardware clears the start bit at completion; it reads as busy.
// - Done flag sets when results are stored; only software clears it.
// - Interrupt request is raised while done is set and enabled.
// - A conversion lasts eleven converter periods: one sample, ten bits.
// - The three channel bits pick one of eight inputs in binary order.
// - Per-pin analog configuration bits mark pins usable as converter input.
// - A start on an unconfigured channel has no effect.
// - The result is a 10-bit code saturating at all ones and zeros.
// - Standard and precision conversion modes are offered.
// - A precision conversion halts the CPU until the conversion ends.
// - Only conversion completion or abort resumes the CPU in precision mode, whatever the interrupt enable.
// - Other interrupts are held pending during a precision conversion.
// - Converter clock is peripheral clock over 64, or over twice the field.
// - With enable clear the converter stands by and never converts.
// - Control bits: precision 6, enable 5, done 4, start 3, channel 2:0.
// - High result holds bits 9 to 2, low result bits 1 and 0.
// - Prescaler field is five bits in the low end, upper bits reserved.
`timescale 1ns/1ps
module adc_conversion_control
(
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            compare_high,
    output adc_ctrl_pkg::analog_ctrl_type        analog,
    output logic      [7:0]                      pin_analog_mode,
    output logic                                 irq_request,
    output logic                                 cpu_halt,
    output logic                                 irq_hold
);

    localparam int CW = adc_ctrl_pkg::CHAN_W;
    localparam int RW = adc_ctrl_pkg::RESULT_W;
    localparam int FW = adc_ctrl_pkg::DIV_FIELD_W;
    localparam int HW = adc_ctrl_pkg::RESULT_HI_W;
    localparam int LW = adc_ctrl_pkg::RESULT_LOW_W;

    // Software-visible state.
    logic          quiet_convert_select;
    logic          converter_enable;
    logic          conv_done_flag;
    logic          conv_start_flag;
    logic [CW-1:0] chan_sel;
    logic [FW-1:0] clock_divider_field;
    logic [7:0]    analog_pin_config;
    logic          converter_irq_enable;
    logic [RW-1:0] result;

    // Sequencer state.
    adc_ctrl_pkg::conv_state_type state;
    adc_ctrl_pkg::conv_state_type next_state;
    logic [CW-1:0] chan_latched;
    logic [RW-1:0] trial;
    logic [RW-1:0] bit_mask;
    logic          precision_run;

    // Bus decode.
    logic          setup_phase;
    logic          access_phase;
    logic          hit_control;
    logic          hit_clock_div;
    logic          hit_pin_config;
    logic          hit_irq_enable;
    logic          hit_result_high;
    logic          hit_result_low;
    logic          hit_any;
    logic          wr_en;
    logic          wr_control;
    logic          wr_clock_div;
    logic          wr_pin_config;
    logic          wr_irq_enable;
    logic [7:0]    control_word;
    logic [31:0]   read_word;

    // Sequencer controls.
    logic          tick;
    logic [CW-1:0] wr_chan;
    logic          start_req;
    logic          abort;
    logic          conv_finish;
    logic          done_clear;
    logic [RW-1:0] trial_decided;
    logic          next_done;

    assign setup_phase     = psel && !penable;
    assign access_phase    = psel && penable;
    assign hit_control     = paddr == adc_ctrl_pkg::ADDR_CONTROL;
    assign hit_clock_div   = paddr == adc_ctrl_pkg::ADDR_CLOCK_DIV;
    assign hit_pin_config  = paddr == adc_ctrl_pkg::ADDR_PIN_CONFIG;
    assign hit_irq_enable  = paddr == adc_ctrl_pkg::ADDR_IRQ_ENABLE;
    assign hit_result_high = paddr == adc_ctrl_pkg::ADDR_RESULT_HIGH;
    assign hit_result_low  = paddr == adc_ctrl_pkg::ADDR_RESULT_LOW;
    assign hit_any         = hit_control || hit_clock_div || hit_pin_config
                          || hit_irq_enable || hit_result_high
                          || hit_result_low;

    // Every access completes in its first access cycle.
    assign pready  = access_phase;
    assign pslverr = access_phase && !hit_any;

    assign wr_en         = access_phase && pwrite;
    assign wr_control    = wr_en && hit_control;
    assign wr_clock_div  = wr_en && hit_clock_div;
    assign wr_pin_config = wr_en && hit_pin_config;
    assign wr_irq_enable = wr_en && hit_irq_enable;

    // Control register image; bit 7 reads as zero.
    assign control_word = {1'b0,
                           quiet_convert_select,
                           converter_enable,
                           conv_done_flag,
                           conv_start_flag,
                           chan_sel};

    assign read_word =
        hit_control     ? {24'h000000, control_word} :
        hit_clock_div   ? {{(32-FW){1'b0}}, clock_divider_field} :
        hit_pin_config  ? {24'h000000, analog_pin_config} :
        hit_irq_enable  ? {30'h0, converter_irq_enable, 1'b0} :
        hit_result_high ? {{(32-HW){1'b0}}, result[RW-1:LW]} :
        hit_result_low  ? {{(32-LW){1'b0}}, result[LW-1:0]} :
        32'h00000000;

    // Read data is captured in the setup cycle and held through access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
        end
        else if (setup_phase && !pwrite)
        begin
            prdata <= read_word;
        end
    end

    // Start is honoured only when enabled, idle and on a configured pin.
    assign wr_chan   = pwdata[adc_ctrl_pkg::CTL_CHAN_LSB +: CW];
    assign start_req = wr_control
                    && pwdata[adc_ctrl_pkg::CTL_START]
                    && pwdata[adc_ctrl_pkg::CTL_ENABLE]
                    && analog_pin_config[wr_chan]
                    && state == adc_ctrl_pkg::ST_IDLE;

    // Dropping enable stops a running conversion without a result.
    assign abort = state != adc_ctrl_pkg::ST_IDLE && !converter_enable;

    assign conv_finish = state == adc_ctrl_pkg::ST_RESOLVE
                      && tick
                      && bit_mask[0]
                      && !abort;

    // Each resolve period keeps or drops its trial bit; the next lower bit is tried after.
    assign trial_decided = compare_high ? trial : (trial & ~bit_mask);

    // Writing zero clears the done flag; a completion in the same cycle wins.
    assign done_clear = wr_control && !pwdata[adc_ctrl_pkg::CTL_DONE];
    assign next_done  = conv_finish || (conv_done_flag && !done_clear);

    always_comb
    begin
        next_state = state;
        case (state)
            adc_ctrl_pkg::ST_IDLE:
            begin
                if (start_req)
                begin
                    next_state = adc_ctrl_pkg::ST_SAMPLE;
                end
            end
            adc_ctrl_pkg::ST_SAMPLE:
            begin
                if (abort)
                begin
                    next_state = adc_ctrl_pkg::ST_IDLE;
                end
                else if (tick)
                begin
                    next_state = adc_ctrl_pkg::ST_RESOLVE;
                end
            end
            adc_ctrl_pkg::ST_RESOLVE:
            begin
                if (abort || conv_finish)
                begin
                    next_state = adc_ctrl_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_state = adc_ctrl_pkg::ST_IDLE;
            end
        endcase
    end

    adc_clock_divider
    #(
        .FIELD_W (FW)
    )
    u_divider
    (
        .pclk          (pclk),
        .presetn       (presetn),
        .restart       (start_req),
        .divider_field (clock_divider_field),
        .tick          (tick)
    );

    // Control register and configuration registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            quiet_convert_select <= 1'b0;
            converter_enable     <= 1'b0;
            chan_sel             <= adc_ctrl_pkg::RST_CHAN;
        end
        else if (wr_control)
        begin
            quiet_convert_select <= pwdata[adc_ctrl_pkg::CTL_QUIET];
            converter_enable     <= pwdata[adc_ctrl_pkg::CTL_ENABLE];
            chan_sel             <= wr_chan;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clock_divider_field <= adc_ctrl_pkg::RST_DIV_FIELD;
        end
        else if (wr_clock_div)
        begin
            clock_divider_field <= pwdata[adc_ctrl_pkg::DIV_FIELD_LSB +: FW];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            analog_pin_config <= adc_ctrl_pkg::RST_PIN_CONFIG;
        end
        else if (wr_pin_config)
        begin
            analog_pin_config <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            converter_irq_enable <= 1'b0;
        end
        else if (wr_irq_enable)
        begin
            converter_irq_enable <= pwdata[adc_ctrl_pkg::IRQEN_BIT];
        end
    end

    // Start flag doubles as the busy indication.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conv_start_flag <= 1'b0;
            conv_done_flag  <= 1'b0;
        end
        else
        begin
            if (start_req)
            begin
                conv_start_flag <= 1'b1;
            end
            else if (conv_finish || abort)
            begin
                conv_start_flag <= 1'b0;
            end
            conv_done_flag <= next_done;
        end
    end

    // Sequencer, channel latch and successive-approximation trial code.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state        <= adc_ctrl_pkg::ST_IDLE;
            chan_latched <= adc_ctrl_pkg::RST_CHAN;
            trial        <= adc_ctrl_pkg::RST_RESULT;
            bit_mask     <= adc_ctrl_pkg::RST_RESULT;
        end
        else
        begin
            state <= next_state;
            if (start_req)
            begin
                chan_latched <= wr_chan;
            end
            if (state == adc_ctrl_pkg::ST_SAMPLE && tick)
            begin
                trial    <= adc_ctrl_pkg::MSB_MASK;
                bit_mask <= adc_ctrl_pkg::MSB_MASK;
            end
            else if (state == adc_ctrl_pkg::ST_RESOLVE && tick)
            begin
                trial    <= trial_decided | (bit_mask >> 1);
                bit_mask <= bit_mask >> 1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result <= adc_ctrl_pkg::RST_RESULT;
        end
        else if (conv_finish)
        begin
            result <= trial_decided;
        end
    end

    // Precision mode halts the CPU from start until completion or abort.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            precision_run <= 1'b0;
        end
        else if (start_req && pwdata[adc_ctrl_pkg::CTL_QUIET])
        begin
            precision_run <= 1'b1;
        end
        else if (conv_finish || abort)
        begin
            precision_run <= 1'b0;
        end
    end

    // Standard mode leaves the CPU running; precision mode halts it.
    assign cpu_halt    = precision_run;
    assign irq_hold    = precision_run;
    assign irq_request = conv_done_flag && converter_irq_enable;

    assign pin_analog_mode = analog_pin_config;

    assign analog.power_on    = converter_enable;
    assign analog.sample_hold = state == adc_ctrl_pkg::ST_SAMPLE;
    assign analog.mux_enable  = state != adc_ctrl_pkg::ST_IDLE;
    assign analog.mux_select  = chan_latched;
    assign analog.trial_code  = trial;

endmodule

// File: src/adc_ctrl_pkg.sv
// Constants, field layouts and types shared by the converter control block.
package adc_ctrl_pkg;

    // APB address width and register indices; byte address is four times.
    localparam int          ADDR_W          = 12;
    localparam logic [7:0]  IDX_CLOCK_DIV   = 8'hF2;
    localparam logic [7:0]  IDX_CONTROL     = 8'hF3;
    localparam logic [7:0]  IDX_RESULT_LOW  = 8'hF4;
    localparam logic [7:0]  IDX_RESULT_HIGH = 8'hF5;
    localparam logic [7:0]  IDX_PIN_CONFIG  = 8'hF6;
    localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'hF7;

    localparam logic [ADDR_W-1:0] ADDR_CLOCK_DIV   = {2'h0, IDX_CLOCK_DIV, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CONTROL     = {2'h0, IDX_CONTROL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_RESULT_LOW  = {2'h0, IDX_RESULT_LOW, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_RESULT_HIGH = {2'h0, IDX_RESULT_HIGH, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PIN_CONFIG  = {2'h0, IDX_PIN_CONFIG, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE  = {2'h0, IDX_IRQ_ENABLE, 2'h0};

    // Control register field positions.
    localparam int CTL_QUIET    = 6;
    localparam int CTL_ENABLE   = 5;
    localparam int CTL_DONE     = 4;
    localparam int CTL_START    = 3;
    localparam int CTL_CHAN_LSB = 0;
    localparam int CHAN_W       = 3;

    // Interrupt enable register field position.
    localparam int IRQEN_BIT = 1;

    // Prescaler field.
    localparam int DIV_FIELD_LSB = 0;
    localparam int DIV_FIELD_W   = 5;

    // Result layout.
    localparam int RESULT_W     = 10;
    localparam int RESULT_LOW_W = 2;
    localparam int RESULT_HI_W  = RESULT_W - RESULT_LOW_W;

    // Reset values.
    localparam logic [CHAN_W-1:0]      RST_CHAN       = 3'h0;
    localparam logic [DIV_FIELD_W-1:0] RST_DIV_FIELD  = 5'h00;
    localparam logic [7:0]             RST_PIN_CONFIG = 8'h00;
    localparam logic [RESULT_W-1:0]    RST_RESULT     = 10'h000;

    // Converter clock ratios and conversion length in converter periods.
    localparam int DIV_ZERO_RATIO = 64;
    localparam int DIV_STEP       = 2;
    localparam int CONV_PERIODS   = 11;

    // First trial bit of a successive-approximation pass.
    localparam logic [RESULT_W-1:0] MSB_MASK = {1'b1, {(RESULT_W-1){1'b0}}};

    // Signals towards the analog multiplexer and converter core.
    typedef struct packed {
        logic                power_on;
        logic                sample_hold;
        logic                mux_enable;
        logic [CHAN_W-1:0]   mux_select;
        logic [RESULT_W-1:0] trial_code;
    } analog_ctrl_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_RESOLVE
    } conv_state_type;

endpackage
